// ---- common/bcm_pkg.sv ----
package bcm_pkg;
  // ------------------------------------------------------------
  // Device numbers and global data windows
  // ------------------------------------------------------------
  localparam int DEV_W = 5;
  localparam logic [5:0] DEV_LIMIT = 6'h20;
  localparam logic [4:0] WIN_FIRST_DEV = 5'h10;
  localparam logic [4:0] WIN_LAST_DEV = 5'h17;
  localparam logic [8:0] WIN_BITS = 9'h020;
  localparam logic [8:0] WIN_BASE_BIT = 9'h001;
  localparam int LEN_W = 9;
  localparam logic [8:0] LEN_MAX_ALL = 9'h100;
  localparam int NUM_WIN = 8;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [4:0] RST_DEV = 5'h10;
  localparam logic [8:0] RST_TX_LEN = 9'h020;
  localparam logic [8:0] RST_RX_LEN = 9'h000;
  // ------------------------------------------------------------
  // Baud settings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BCM_RATE_STD,
    BCM_RATE_EXT,
    BCM_RATE_76K8,
    BCM_RATE_38K4
  } bcm_rate_e;
  localparam bcm_rate_e RST_RATE = BCM_RATE_STD;
  localparam logic [5:0] SLOW_RATE_MAX_STATIONS = 6'h10;
  // ------------------------------------------------------------
  // Command codes on the configuration port
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BCM_CMD_DEV,
    BCM_CMD_RATE,
    BCM_CMD_TX_LEN,
    BCM_CMD_RX_LEN,
    BCM_CMD_DEFAULTS
  } bcm_cmd_e;

  // Largest length allowed at a device number; zero outside windows
  function automatic logic [8:0] max_len(input logic [4:0] dev);
    logic [8:0] k;
    k = 9'h000;
    if (dev >= WIN_FIRST_DEV && dev <= WIN_LAST_DEV) begin
      k = {4'h0, dev - WIN_FIRST_DEV};
      return LEN_MAX_ALL - (k << 5);
    end
    return 9'h000;
  endfunction

  // First global data bit of a window
  function automatic logic [8:0] win_start(input logic [4:0] dev);
    logic [8:0] k;
    k = {4'h0, dev - WIN_FIRST_DEV};
    return WIN_BASE_BIT + (k << 5);
  endfunction

  function automatic logic len_ok(input logic [4:0] dev, input logic [8:0] len);
    return (len[4:0] == 5'h00) && (len <= max_len(dev));
  endfunction
endpackage

// ---- common/bcm_if.sv ----
`timescale 1ns/10ps
interface bcm_if;
  logic cfg_valid;
  bcm_pkg::bcm_cmd_e cfg_cmd;
  logic [4:0] cfg_dev;
  logic [8:0] cfg_value;
  logic cfg_ready;
  logic cfg_reject;
  logic run_mode;
  logic [4:0] token_now;
  logic tx_slot;
  logic [255:0] gd_out;
  logic [255:0] gd_in;
  logic gd_in_valid;

  modport dev (
    input cfg_valid, cfg_cmd, cfg_dev, cfg_value, run_mode, token_now, gd_out,
    output cfg_ready, cfg_reject, tx_slot, gd_in, gd_in_valid
  );
  modport host (
    output cfg_valid, cfg_cmd, cfg_dev, cfg_value, run_mode, token_now, gd_out,
    input cfg_ready, cfg_reject, tx_slot, gd_in, gd_in_valid
  );
endinterface

// ---- rtl/bcm_comms_module.sv ----
`timescale 1ns/10ps
// Operation
// - Device number accepted in range 0..31
// - Device number sets token transmit position
// - Configurer assigns every module a number
// - Numbers 16..23 map to 32-bit windows
// - Max length 256 down to 32 bits
// - Long data claims following numbers' windows
// - Claimed numbers still fine for receive-only
// - Defaults: send 32 bits, receive none
// - Four selectable rates, same bus-wide
// - Default rate is 153.6k standard
// - Slowest rate allows sixteen stations at most; no check of this here
// - Configurer defines rate, number and lengths
// - Settings change only in stop mode
// - Stop mode broadcasts all-zero data
// - Run mode exchanges real data
// - Lengths are multiples of 32, zero none
module bcm_comms_module (
  input wire logic ref_clk,
  input wire logic rst_n,
  bcm_if.dev link,
  output logic [4:0] dev_num,
  output bcm_pkg::bcm_rate_e rate_sel,
  output logic rate_standard_option,
  output logic [8:0] tx_len,
  output logic [7:0] rx_enable,
  output logic [7:0] claimed,
  output logic [255:0] bus_tx_data,
  output logic bus_tx_valid,
  input wire logic [255:0] bus_rx_data,
  input wire logic [4:0] bus_rx_dev,
  input wire logic bus_rx_valid
);
  // ----------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------
  logic [8:0] rx_len [bcm_pkg::NUM_WIN];
  logic accept;
  logic [2:0] rx_idx;
  logic [255:0] rx_mask;
  logic [255:0] gd_in_q;
  logic gd_in_valid_q;

  assign rx_idx = link.cfg_dev[2:0];
  assign link.cfg_ready = 1'b1;

  // Writes only in stop mode, so the bus never sees a half-applied setup
  always_comb begin
    accept = 1'b0;
    if (link.cfg_valid && !link.run_mode) begin
      unique case (link.cfg_cmd)
        bcm_pkg::BCM_CMD_DEV:
          accept = {1'b0, link.cfg_value[4:0]} < bcm_pkg::DEV_LIMIT
            && link.cfg_value[8:5] == 4'h0;
        bcm_pkg::BCM_CMD_RATE: accept = link.cfg_value[8:2] == 7'h00;
        bcm_pkg::BCM_CMD_TX_LEN: accept = bcm_pkg::len_ok(dev_num, link.cfg_value);
        bcm_pkg::BCM_CMD_RX_LEN:
          accept = link.cfg_dev != dev_num && !claimed[rx_idx]
            && link.cfg_dev >= bcm_pkg::WIN_FIRST_DEV
            && link.cfg_dev <= bcm_pkg::WIN_LAST_DEV
            && bcm_pkg::len_ok(link.cfg_dev, link.cfg_value);
        bcm_pkg::BCM_CMD_DEFAULTS: accept = 1'b1;
        default: accept = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link.cfg_reject <= 1'b0;
    end else begin
      link.cfg_reject <= link.cfg_valid && !accept;
    end
  end

  // Defaults leave the number alone so the station keeps its bus slot
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dev_num <= bcm_pkg::RST_DEV;
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_DEV) begin
      dev_num <= link.cfg_value[4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rate_sel <= bcm_pkg::RST_RATE;
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_RATE) begin
      rate_sel <= bcm_pkg::bcm_rate_e'(link.cfg_value[1:0]);
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_DEFAULTS) begin
      rate_sel <= bcm_pkg::RST_RATE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_len <= bcm_pkg::RST_TX_LEN;
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_TX_LEN) begin
      tx_len <= link.cfg_value;
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_DEFAULTS) begin
      tx_len <= bcm_pkg::RST_TX_LEN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < bcm_pkg::NUM_WIN; i++) begin
        rx_len[i] <= bcm_pkg::RST_RX_LEN;
      end
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_RX_LEN) begin
      rx_len[rx_idx] <= link.cfg_value;
    end else if (accept && link.cfg_cmd == bcm_pkg::BCM_CMD_DEFAULTS) begin
      for (int i = 0; i < bcm_pkg::NUM_WIN; i++) begin
        rx_len[i] <= bcm_pkg::RST_RX_LEN;
      end
    end
  end

  assign rate_standard_option = rate_sel == bcm_pkg::BCM_RATE_STD;

  // ----------------------------------------------------------
  // Window claims
  // ----------------------------------------------------------
  // A sender longer than one window claims the numbers after it
  always_comb begin
    logic [8:0] span;
    logic [8:0] lo;
    span = 9'h000;
    lo = 9'h000;
    claimed = 8'h00;
    for (int i = 0; i < bcm_pkg::NUM_WIN; i++) begin
      lo = bcm_pkg::win_start(bcm_pkg::WIN_FIRST_DEV + 5'(i));
      if (dev_num >= bcm_pkg::WIN_FIRST_DEV && dev_num <= bcm_pkg::WIN_LAST_DEV) begin
        span = bcm_pkg::win_start(dev_num);
        if (lo > span && lo < span + tx_len) begin
          claimed[i] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < bcm_pkg::NUM_WIN; i++) begin
      rx_enable[i] = rx_len[i] != 9'h000;
    end
  end

  // ----------------------------------------------------------
  // Length masks
  // ----------------------------------------------------------
  // Bits past the configured length never reach the bus
  function automatic logic [255:0] len_mask(input logic [8:0] len);
    logic [255:0] m;
    m = 256'h0;
    for (int b = 0; b < 256; b++) begin
      m[b] = 9'(b) < len;
    end
    return m;
  endfunction

  logic [255:0] tx_mask;
  assign tx_mask = len_mask(tx_len);

  // ----------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------
  assign link.tx_slot = link.token_now == dev_num;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_tx_data <= 256'h0;
      bus_tx_valid <= 1'b0;
    end else begin
      bus_tx_valid <= link.tx_slot && tx_len != 9'h000;
      if (link.run_mode) begin
        bus_tx_data <= link.gd_out & tx_mask;
      end else begin
        bus_tx_data <= 256'h0;
      end
    end
  end

  // ----------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------
  // Mask keeps only the sender's own configured window span
  always_comb begin
    logic [8:0] base;
    logic [8:0] pos;
    base = 9'h000;
    pos = 9'h000;
    rx_mask = 256'h0;
    if (bus_rx_dev >= bcm_pkg::WIN_FIRST_DEV && bus_rx_dev <= bcm_pkg::WIN_LAST_DEV) begin
      base = bcm_pkg::win_start(bus_rx_dev) - bcm_pkg::WIN_BASE_BIT;
      for (int b = 0; b < 256; b++) begin
        pos = 9'(b);
        rx_mask[b] = pos >= base && pos < base + rx_len[bus_rx_dev[2:0]];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gd_in_q <= 256'h0;
      gd_in_valid_q <= 1'b0;
    end else begin
      gd_in_valid_q <= 1'b0;
      if (bus_rx_valid && link.run_mode && rx_mask != 256'h0) begin
        gd_in_q <= (gd_in_q & ~rx_mask) | (bus_rx_data & rx_mask);
        gd_in_valid_q <= 1'b1;
      end
    end
  end

  assign link.gd_in = gd_in_q;
  assign link.gd_in_valid = gd_in_valid_q;
endmodule

// ---- rtl/bcm_host_cpu.sv ----
`timescale 1ns/10ps
module bcm_host_cpu (
  input wire logic ref_clk,
  input wire logic rst_n,
  bcm_if.host link,
  input wire logic req_valid,
  input wire bcm_pkg::bcm_cmd_e req_cmd,
  input wire logic [4:0] req_dev,
  input wire logic [8:0] req_value,
  output logic req_ready,
  output logic req_reject,
  input wire logic run_req,
  input wire logic [4:0] token_in,
  input wire logic [255:0] app_out,
  output logic [255:0] app_in
);
  // ----------------------------------------------------------
  // Mode and configuration issue
  // ----------------------------------------------------------
  logic configured;

  // Ready drops while running; settings move in stop only
  assign req_ready = !link.run_mode;
  // Run-mode requests still reach the module so it reports the refusal
  assign link.cfg_valid = req_valid;
  assign link.cfg_cmd = req_cmd;
  assign link.cfg_dev = req_dev;
  assign link.cfg_value = req_value;
  assign req_reject = link.cfg_reject;
  assign link.token_now = token_in;
  assign link.gd_out = app_out;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      configured <= 1'b0;
    end else if (link.cfg_valid && req_cmd == bcm_pkg::BCM_CMD_DEV) begin
      configured <= 1'b1;
    end
  end

  // Run only after a number has been given
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link.run_mode <= 1'b0;
    end else begin
      link.run_mode <= run_req && configured;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      app_in <= 256'h0;
    end else if (link.gd_in_valid) begin
      app_in <= link.gd_in;
    end
  end
endmodule

// ---- testbench/bcm_checker.sv ----
`timescale 1ns/10ps
module bcm_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cfg_valid,
  input wire bcm_pkg::bcm_cmd_e cfg_cmd,
  input wire logic [4:0] cfg_dev,
  input wire logic [8:0] cfg_value,
  input wire logic cfg_reject,
  input wire logic run_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Requests taken in stop mode
  // ----
  sequence s_take;
    cfg_valid && !run_mode;
  endsequence
  sequence s_rx;
    s_take ##0 cfg_cmd == bcm_pkg::BCM_CMD_RX_LEN;
  endsequence
  property p_run;
    cfg_valid && run_mode |=> cfg_reject;
  endproperty
  a_run: assert property (p_run) else $error("run request kept");
  property p_dev_bad;
    s_take ##0 (cfg_cmd == bcm_pkg::BCM_CMD_DEV && cfg_value > 9'h01f) |=> cfg_reject;
  endproperty
  a_dev_bad: assert property (p_dev_bad) else $error("bad number kept");
  property p_dev_ok;
    s_take ##0 (cfg_cmd == bcm_pkg::BCM_CMD_DEV && cfg_value < 9'h020) |=> !cfg_reject;
  endproperty
  a_dev_ok: assert property (p_dev_ok) else $error("good number refused");
  property p_frac;
    s_take ##0 (cfg_cmd inside {bcm_pkg::BCM_CMD_TX_LEN, bcm_pkg::BCM_CMD_RX_LEN})
      ##0 cfg_value[4:0] != 5'h00 |=> cfg_reject;
  endproperty
  a_frac: assert property (p_frac) else $error("odd length kept");
  property p_far;
    s_rx ##0 cfg_dev[4:3] != 2'h2 |=> cfg_reject;
  endproperty
  a_far: assert property (p_far) else $error("no window kept");
  // Outside 16..23 the limit is meaningless, but a_far covers those
  property p_max;
    s_rx ##0 cfg_value > 9'h100 - {1'b0, cfg_dev[2:0], 5'h00} |=> cfg_reject;
  endproperty
  a_max: assert property (p_max) else $error("long length kept");
  property p_rate;
    s_take ##0 (cfg_cmd == bcm_pkg::BCM_CMD_RATE && cfg_value > 9'h003) |=> cfg_reject;
  endproperty
  a_rate: assert property (p_rate) else $error("bad rate kept");
  property p_src;
    cfg_reject |-> $past(cfg_valid);
  endproperty
  a_src: assert property (p_src) else $error("refusal without request");
endmodule

// ---- testbench/global_data_bus_config_tb.sv ----
`timescale 1ns/10ps
module global_data_bus_config_tb;
  logic ref_clk, rst_n, req_valid, req_ready, req_reject, run_req, bus_tx_valid, bus_rx_valid;
  bcm_pkg::bcm_cmd_e req_cmd;
  bcm_pkg::bcm_rate_e rate_sel;
  logic [4:0] req_dev, token_in, dev_num, bus_rx_dev;
  logic [8:0] req_value, tx_len;
  logic [7:0] rx_enable, claimed;
  logic [255:0] app_out, app_in, bus_tx_data, bus_rx_data;
  int failures, cmp_count, m_dev, m_tx, m_rate, m_rx[8], c, d, v;
  bcm_if link ();
  bcm_comms_module bcm_comms_module_i (.ref_clk, .rst_n, .link(link.dev), .dev_num,
    .rate_sel, .rate_standard_option(), .tx_len, .rx_enable, .claimed, .bus_tx_data,
    .bus_tx_valid, .bus_rx_data, .bus_rx_dev, .bus_rx_valid);
  bcm_host_cpu bcm_host_cpu_i (.ref_clk, .rst_n, .link(link.host), .req_valid, .req_cmd,
    .req_dev, .req_value, .req_ready, .req_reject, .run_req, .token_in, .app_out, .app_in);
  bcm_checker bcm_checker_i (.ref_clk, .rst_n, .cfg_valid(link.cfg_valid),
    .cfg_cmd(link.cfg_cmd), .cfg_dev(link.cfg_dev), .cfg_value(link.cfg_value),
    .cfg_reject(link.cfg_reject), .run_mode(link.run_mode));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #50us;
    failures++;
    report_and_stop();
  end
  // ----
  // Expectations
  // ----
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [255:0] e, input logic [255:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic int lmax(int d);
    return (d > 15 && d < 24) ? 256 - 32 * (d - 16) : 0;
  endfunction
  task automatic dflt();
    m_tx = 32;
    m_rate = 0;
    m_rx = '{default: 0};
  endtask
  // Command codes follow the enum order; refusal predicted before sending
  task automatic cfg(input int c, input int d, input int v);
    logic got;
    logic [7:0] er, ec;
    bit rej;
    rej = !req_ready || (c == 0 && v > 31) || (c == 1 && v > 3)
      || (c == 2 && (v % 32 != 0 || v > lmax(m_dev)))
      || (c == 3 && (v % 32 != 0 || v > lmax(d) || lmax(d) == 0 || d == m_dev
      || (d > m_dev && d < m_dev + m_tx / 32)));
    req_valid <= 1'b1;
    req_cmd <= bcm_pkg::bcm_cmd_e'(c);
    req_dev <= 5'(d);
    req_value <= 9'(v);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    got = 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      got = got | req_reject;
    end
    chk("reject", rej, got);
    if (!rej) begin
      case (c)
        0: m_dev = v;
        1: m_rate = v;
        2: m_tx = v;
        3: m_rx[d - 16] = v;
        default: dflt();
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      er[i] = m_rx[i] != 0;
      ec[i] = i + 16 > m_dev && i + 16 < m_dev + m_tx / 32;
    end
    chk("dev", m_dev, dev_num);
    chk("tx_len", m_tx, tx_len);
    chk("rate", m_rate, rate_sel);
    chk("rx_en", er, rx_enable);
    chk("claim", ec, claimed);
  endtask
  task automatic tx_probe(input logic [31:0] e);
    logic [31:0] s;
    s = ~e;
    token_in <= dev_num;
    repeat (4) begin
      @(posedge ref_clk);
      if (bus_tx_valid === 1'b1) begin
        s = bus_tx_data[31:0];
      end
    end
    token_in <= 5'h00;
    chk("tx", e, s);
  endtask
  // ----
  // Stimulus
  // ----
  initial begin
    void'($urandom(29239));
    failures = 0;
    cmp_count = 0;
    m_dev = 16;
    {rst_n, req_valid, run_req, bus_rx_valid} = 4'h0;
    req_cmd = bcm_pkg::BCM_CMD_DEV;
    {req_dev, token_in, bus_rx_dev, req_value} = 24'h000000;
    app_out = {8{$urandom()}};
    bus_rx_data = ~app_out;
    dflt();
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("rst", {14'h2020, 10'h000}, {dev_num, tx_len, rate_sel, rx_enable});
    cfg(0, 0, 32);
    cfg(0, 0, 31);
    cfg(2, 0, 32);
    cfg(0, 0, 16);
    cfg(2, 0, 96);
    for (int w = 15; w < 25; w++) begin
      cfg(3, w, lmax(w) + 32);
      cfg(3, w, lmax(w));
    end
    // Own number kept inside 16..23 so claims stay unambiguous
    repeat (150) begin
      c = $urandom_range(4);
      d = $urandom_range(24, 15);
      v = c == 0 ? 16 + d % 8 + 16 * $urandom_range(1) : c == 1 ? $urandom_range(4)
        : 32 * $urandom_range(9) + ($urandom_range(7) == 0);
      cfg(c, d, v);
    end
    cfg(4, 0, 0);
    cfg(0, 0, 18);
    cfg(3, 20, 64);
    tx_probe(32'h00000000);
    run_req <= 1'b1;
    for (d = 0; d < 20 && req_ready !== 1'b0; d++) begin
      @(posedge ref_clk);
    end
    cfg(1, 0, 2);
    tx_probe(app_out[31:0]);
    bus_rx_dev <= 5'h14;
    bus_rx_valid <= 1'b1;
    @(posedge ref_clk);
    bus_rx_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("rx_win", bus_rx_data[191:128], app_in[191:128]);
    chk("rx_rest", 256'h0, {app_in[255:192], app_in[127:0]});
    report_and_stop();
  end
endmodule
